// *** src/tmr8_wave_ctrl.sv ***
// 8-bit timer/counter with two compare channels and waveform outputs.
// Assumes synchronous inputs on clk and an Avalon-MM master on the bus.
// Contract
// RULE1: Counter runs on clk; the tick only enables counting, never clocks.
// RULE2: Nonzero channel output mode routes compare output onto its pin.
// RULE3: Pin driver enabled only while the pin direction selects output.
// RULE4: Non-PWM output modes: off, toggle, clear or set on match.
// RULE5: Fast PWM channel A: 10 clear on match, set at TOP; 11 reverse.
// RULE6: PWM channel A mode 01 toggles only with high mode bit set.
// RULE7: Fast PWM channel B: 10 and 11 as channel A; 01 reserved.
// RULE8: Phase PWM channel A: 10 clears going up, sets going down.
// RULE9: Phase PWM channel B behaves like A; mode 01 reserved.
// RULE10: PWM with compare equal TOP and upper bit set: ignore match.
// RULE11: Waveform mode is three bits split over both control registers.
// RULE12: TOP is 0xFF in modes 0,1,3; channel A compare in 2,5,7.
// RULE13: Compare writes immediate outside PWM, loaded at TOP in PWM.
// RULE14: Overflow sets at MAX in 0,2,3; BOTTOM in 1,5; TOP in 7.
// RULE15: Channel compare flags set on every compare match.
// RULE16: Clear-on-match and fast PWM A-top: A match sets flag, clears.
// RULE17: Reserved control bits read as zero.
// RULE18: Control B holds force strobes, high mode bit, tick select.
// RULE19: Force strobe outside PWM acts on output only; reads zero.
// RULE20: Tick select: stop, divide 1/8/64/256/1024, external edges.
// RULE21: Reserved bit writes ignored; reserved modes disconnect output.
`timescale 1ns/1ns
`default_nettype none
module tmr8_wave_ctrl
    import tmr8_pkg::*;
#(
    parameter int PRESC_W = 10
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // External tick pin
    input wire logic ext_tick_in,
    // Port side of the two shared pins
    input wire logic chan_a_dir,
    input wire logic chan_b_dir,
    input wire logic port_a_out,
    input wire logic port_b_out,
    // Pin drivers
    output logic pin_a_out,
    output logic pin_a_oe,
    output logic pin_b_out,
    output logic pin_b_oe,
    // Status
    output logic chan_a_wave_out,
    output logic chan_b_wave_out,
    output logic overflow_flag,
    output logic chan_a_match_flag,
    output logic chan_b_match_flag
);
    function automatic logic is_pwm(input logic [2:0] m);
        is_pwm = (m == WM_PC_FF) || (m == WM_FAST_FF) ||
                 (m == WM_PC_A) || (m == WM_FAST_A);
    endfunction

    function automatic logic is_fast(input logic [2:0] m);
        is_fast = (m == WM_FAST_FF) || (m == WM_FAST_A);
    endfunction

    // Output connected unless its output mode is off, a reserved mode is selected, or it toggles in PWM other than channel A with the high mode bit set
    function automatic logic conn(input logic [2:0] m, input logic [1:0] c,
                                  input logic chan_a);
        conn = (c != OM_OFF) && (m != WM_RESV4) && (m != WM_RESV6) &&
               !(is_pwm(m) && c == OM_TOGGLE && !(chan_a && m[2]));
    endfunction

    function automatic logic wave_next(input logic [2:0] m,
                                       input logic [1:0] c, input logic w,
                                       input logic hit, input logic top,
                                       input logic up, input logic eq_top);
        logic h;
        h = hit;
        wave_next = w;
        if (is_pwm(m) && c[1] && eq_top) begin
            h = 1'b0; // RULE10
        end
        if (!is_pwm(m)) begin
            if (h) begin
                case (c) // RULE4
                    OM_TOGGLE: wave_next = !w;
                    OM_CLEAR: wave_next = 1'b0;
                    OM_SET: wave_next = 1'b1;
                    default: wave_next = w;
                endcase
            end
        end else if (c == OM_TOGGLE) begin
            if (h) begin
                wave_next = !w; // RULE6
            end
        end else if (c[1] && is_fast(m)) begin
            if (top) begin
                wave_next = !c[0]; // RULE5 RULE7
            end else if (h) begin
                wave_next = c[0];
            end
        end else if (c[1]) begin
            if (top && eq_top) begin
                wave_next = !c[0]; // RULE10
            end else if (h) begin
                wave_next = up ? c[0] : !c[0]; // RULE8 RULE9
            end
        end
    endfunction

    tmr8_bus_e bus_q, bus_d;
    logic [31:0] rdata_q, rdata_d;
    logic [7:0] ctrl_a_q, ctrl_a_d, ctrl_b_q, ctrl_b_d;
    logic [7:0] cnt_q, cnt_d;
    logic [7:0] buf_a_q, buf_a_d, buf_b_q, buf_b_d;
    logic [7:0] act_a_q, act_a_d, act_b_q, act_b_d;
    logic up_q, up_d;
    logic block_q;
    logic [PRESC_W-1:0] presc_q;
    logic ext_prev_q;
    logic wave_a_q, wave_a_d, wave_b_q, wave_b_d;
    logic ovf_q, ovf_d, fla_q, fla_d, flb_q, flb_d;

    // Bus decode
    wire req = avs_read | avs_write;
    wire fire = (bus_q == TMR8_BUS_ANS) & req;
    wire wr = fire & avs_write & avs_byteenable[0];
    wire [7:0] wd = avs_writedata[7:0];
    wire wr_ctrl_a = wr & (avs_address == ADDR_CTRL_A);
    wire wr_ctrl_b = wr & (avs_address == ADDR_CTRL_B);
    wire wr_cnt = wr & (avs_address == ADDR_COUNT);
    wire wr_cmp_a = wr & (avs_address == ADDR_CMP_A);
    wire wr_cmp_b = wr & (avs_address == ADDR_CMP_B);
    wire wr_flags = wr & (avs_address == ADDR_FLAGS);
    wire [7:0] flags_v = {5'h00, flb_q, fla_q, ovf_q};
    logic [7:0] rd_mux;
    assign avs_waitrequest = req & (bus_q == TMR8_BUS_IDLE);
    assign avs_readdata = rdata_q;

    // Mode decode
    wire [1:0] com_a = ctrl_a_q[CA_OUT_A_LSB+:2];
    wire [1:0] com_b = ctrl_a_q[CA_OUT_B_LSB+:2];
    wire [2:0] tick_sel = ctrl_b_q[CB_TICK_LSB+:3];
    wire [2:0] mode = {ctrl_b_q[CB_WAVE_HI_BIT],
                       ctrl_a_q[CA_WAVE_LSB+:2]}; // RULE11
    wire pwm = is_pwm(mode);
    wire fast = is_fast(mode);
    wire pc = pwm & !fast;
    wire top_is_a = (mode == WM_CLEAR) || (mode == WM_PC_A) ||
                    (mode == WM_FAST_A);
    wire [7:0] top_val = top_is_a ? act_a_q : CNT_MAX; // RULE12

    // Tick source; stop resets the prescaler so division starts clean
    wire ext_fall = ext_prev_q & !ext_tick_in;
    wire ext_rise = !ext_prev_q & ext_tick_in;
    logic tick;
    always_comb begin
        case (tick_sel) // RULE20
            TS_DIV1: tick = 1'b1;
            TS_DIV8: tick = &presc_q[2:0];
            TS_DIV64: tick = &presc_q[5:0];
            TS_DIV256: tick = &presc_q[7:0];
            TS_DIV1024: tick = &presc_q[9:0];
            TS_EXT_FALL: tick = ext_fall;
            TS_EXT_RISE: tick = ext_rise;
            default: tick = 1'b0;
        endcase
    end

    // Compare events
    wire at_top = tick & (cnt_q == top_val);
    wire at_bot = tick & (cnt_q == CNT_BOTTOM);
    wire match_a = tick & !block_q & (cnt_q == act_a_q);
    wire match_b = tick & !block_q & (cnt_q == act_b_q);
    wire frc_a = wr_ctrl_b & wd[CB_FORCE_A_BIT] & !pwm; // RULE19
    wire frc_b = wr_ctrl_b & wd[CB_FORCE_B_BIT] & !pwm; // RULE19
    wire conn_a = conn(mode, com_a, 1'b1);
    wire conn_b = conn(mode, com_b, 1'b0);
    wire ovf_hit = ((mode == WM_NORMAL || mode == WM_CLEAR ||
                     mode == WM_FAST_FF) && tick && cnt_q == CNT_MAX) ||
                   (pc && at_bot) ||
                   (mode == WM_FAST_A && at_top); // RULE14

    // Pins take the wave only when routed; direction owns the driver
    assign pin_a_out = conn_a ? wave_a_q : port_a_out; // RULE2 RULE21
    assign pin_b_out = conn_b ? wave_b_q : port_b_out; // RULE2 RULE21
    assign pin_a_oe = chan_a_dir; // RULE3
    assign pin_b_oe = chan_b_dir; // RULE3
    assign chan_a_wave_out = wave_a_q;
    assign chan_b_wave_out = wave_b_q;
    assign overflow_flag = ovf_q;
    assign chan_a_match_flag = fla_q;
    assign chan_b_match_flag = flb_q;

    always_comb begin
        if (avs_address == ADDR_CTRL_A) begin
            rd_mux = ctrl_a_q & CTRL_A_WMASK; // RULE17
        end else if (avs_address == ADDR_CTRL_B) begin
            rd_mux = ctrl_b_q & CTRL_B_WMASK; // RULE17 RULE19
        end else if (avs_address == ADDR_COUNT) begin
            rd_mux = cnt_q;
        end else if (avs_address == ADDR_CMP_A) begin
            rd_mux = buf_a_q;
        end else if (avs_address == ADDR_CMP_B) begin
            rd_mux = buf_b_q;
        end else if (avs_address == ADDR_FLAGS) begin
            rd_mux = flags_v;
        end else begin
            rd_mux = 8'h00;
        end
    end

    always_comb begin
        bus_d = bus_q;
        case (bus_q)
            TMR8_BUS_IDLE: if (req) bus_d = TMR8_BUS_ANS;
            TMR8_BUS_ANS: bus_d = TMR8_BUS_IDLE;
            default: bus_d = TMR8_BUS_IDLE;
        endcase
        rdata_d = rdata_q;
        if (bus_q == TMR8_BUS_IDLE && avs_read) begin
            rdata_d = {24'h00_0000, rd_mux};
        end
    end

    always_comb begin
        ctrl_a_d = wr_ctrl_a ? (wd & CTRL_A_WMASK) : ctrl_a_q; // RULE21
        // Force strobes are never stored
        ctrl_b_d = wr_ctrl_b ? (wd & CTRL_B_WMASK) : ctrl_b_q; // RULE18
        buf_a_d = wr_cmp_a ? wd : buf_a_q;
        buf_b_d = wr_cmp_b ? wd : buf_b_q;
        act_a_d = pwm ? (at_top ? buf_a_q : act_a_q) : buf_a_d; // RULE13
        act_b_d = pwm ? (at_top ? buf_b_q : act_b_q) : buf_b_d; // RULE13
    end

    always_comb begin
        cnt_d = cnt_q;
        up_d = up_q;
        if (wr_cnt) begin
            cnt_d = wd;
        end else if (tick) begin // RULE1
            if (pc) begin
                if (up_q && cnt_q == top_val) begin
                    up_d = 1'b0;
                    cnt_d = cnt_q - 8'h01;
                end else if (!up_q && cnt_q == CNT_BOTTOM) begin
                    up_d = 1'b1;
                    cnt_d = cnt_q + 8'h01;
                end else begin
                    cnt_d = up_q ? cnt_q + 8'h01 : cnt_q - 8'h01;
                end
            end else if (top_is_a || fast) begin
                cnt_d = (cnt_q == top_val) ? CNT_BOTTOM
                                           : cnt_q + 8'h01; // RULE16
            end else begin
                up_d = 1'b1;
                cnt_d = cnt_q + 8'h01;
            end
        end
    end

    always_comb begin
        wave_a_d = wave_next(mode, com_a, wave_a_q, match_a | frc_a, at_top,
                             up_q, act_a_q == top_val);
        wave_b_d = wave_next(mode, com_b, wave_b_q, match_b | frc_b, at_top,
                             up_q, act_b_q == top_val);
        // A clear that meets a new event keeps the flag set
        ovf_d = ovf_hit | (ovf_q & !(wr_flags & wd[FL_OVF_BIT]));
        fla_d = match_a | (fla_q & !(wr_flags & wd[FL_A_BIT])); // RULE15
        flb_d = match_b | (flb_q & !(wr_flags & wd[FL_B_BIT])); // RULE15
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_q <= TMR8_BUS_IDLE;
            rdata_q <= 32'h0000_0000;
            ctrl_a_q <= CTRL_A_RESET;
            ctrl_b_q <= CTRL_B_RESET;
            buf_a_q <= CMP_RESET;
            buf_b_q <= CMP_RESET;
            act_a_q <= CMP_RESET;
            act_b_q <= CMP_RESET;
        end else begin
            bus_q <= bus_d;
            rdata_q <= rdata_d;
            ctrl_a_q <= ctrl_a_d;
            ctrl_b_q <= ctrl_b_d;
            buf_a_q <= buf_a_d;
            buf_b_q <= buf_b_d;
            act_a_q <= act_a_d;
            act_b_q <= act_b_d;
        end
    end

    // A software count write masks the compare on the next tick
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= COUNT_RESET;
            up_q <= 1'b1;
            block_q <= 1'b0;
            presc_q <= '0;
            ext_prev_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            up_q <= up_d;
            block_q <= wr_cnt | (block_q & !tick);
            presc_q <= (tick_sel == TS_STOP) ? '0 : presc_q + 1'b1;
            ext_prev_q <= ext_tick_in;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wave_a_q <= 1'b0;
            wave_b_q <= 1'b0;
            ovf_q <= 1'b0;
            fla_q <= 1'b0;
            flb_q <= 1'b0;
        end else begin
            wave_a_q <= wave_a_d;
            wave_b_q <= wave_b_d;
            ovf_q <= ovf_d;
            fla_q <= fla_d;
            flb_q <= flb_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    chk_count_needs_tick: assert property ( // RULE1
        (!tick && !wr_cnt) |=> $stable(cnt_q))
        else $error("count moved without tick");
    chk_pin_routing: assert property ( // RULE2
        (com_a != OM_OFF && !pwm && !mode[2]) |-> pin_a_out == wave_a_q)
        else $error("pin A routing wrong");
    chk_dir_gates_pin: assert property ( // RULE3
        pin_b_oe == chan_b_dir && pin_a_oe == chan_a_dir)
        else $error("pin enable not from direction");
    chk_nonpwm_toggle: assert property ( // RULE4
        (mode == WM_NORMAL && com_a == OM_TOGGLE && match_a && !frc_a)
        |=> wave_a_q != $past(wave_a_q))
        else $error("no toggle on match");
    chk_fast_set_top: assert property ( // RULE5
        (fast && com_a == OM_CLEAR && at_top) |=> wave_a_q)
        else $error("fast PWM not set at TOP");
    chk_pc_clear_up: assert property ( // RULE8
        (pc && com_a == OM_CLEAR && match_a && up_q &&
         act_a_q != top_val) |=> !wave_a_q)
        else $error("phase PWM not cleared going up");
    chk_top_match_ignored: assert property ( // RULE10
        (fast && com_b == OM_CLEAR && match_b && act_b_q == top_val)
        |=> wave_b_q)
        else $error("match at TOP not ignored");
    chk_cmp_buffered: assert property ( // RULE13
        (pwm && !at_top) |=> $stable(act_a_q))
        else $error("compare loaded outside TOP");
    chk_ovf_at_max: assert property ( // RULE14
        (tick && mode == WM_NORMAL && cnt_q == CNT_MAX) |=> ovf_q)
        else $error("overflow flag missed");

    cov_fast_pwm_top: cover property (fast && at_top && conn_a);
    cov_pc_turn: cover property (pc && up_q ##1 !up_q);
    cov_force_a: cover property (frc_a && com_a == OM_TOGGLE);
    cov_flag_clear_race: cover property (match_b && wr_flags);
endmodule
`default_nettype wire

// *** src/tmr8_pkg.sv ***
// Constants for the 8-bit timer waveform and compare control block.
// Assumes a single clock domain; register offsets are byte addresses.
package tmr8_pkg;
    // Register byte offsets, one 32-bit word each
    localparam logic [4:0] ADDR_CTRL_A = 5'h00;
    localparam logic [4:0] ADDR_CTRL_B = 5'h04;
    localparam logic [4:0] ADDR_COUNT = 5'h08;
    localparam logic [4:0] ADDR_CMP_A = 5'h0C;
    localparam logic [4:0] ADDR_CMP_B = 5'h10;
    localparam logic [4:0] ADDR_FLAGS = 5'h14;
    // Control A field positions
    localparam int CA_OUT_A_LSB = 6;
    localparam int CA_OUT_B_LSB = 4;
    localparam int CA_WAVE_LSB = 0;
    // Control B field positions
    localparam int CB_FORCE_A_BIT = 7;
    localparam int CB_FORCE_B_BIT = 6;
    localparam int CB_WAVE_HI_BIT = 3;
    localparam int CB_TICK_LSB = 0;
    // Flag register bit positions
    localparam int FL_OVF_BIT = 0;
    localparam int FL_A_BIT = 1;
    localparam int FL_B_BIT = 2;
    // Writable masks of the control registers
    localparam logic [7:0] CTRL_A_WMASK = 8'hF3;
    localparam logic [7:0] CTRL_B_WMASK = 8'h0F;
    // Reset values
    localparam logic [7:0] CTRL_A_RESET = 8'h00;
    localparam logic [7:0] CTRL_B_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] CMP_RESET = 8'h00;
    // Counter extremes
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    // Waveform modes
    localparam logic [2:0] WM_NORMAL = 3'h0;
    localparam logic [2:0] WM_PC_FF = 3'h1;
    localparam logic [2:0] WM_CLEAR = 3'h2;
    localparam logic [2:0] WM_FAST_FF = 3'h3;
    localparam logic [2:0] WM_RESV4 = 3'h4;
    localparam logic [2:0] WM_PC_A = 3'h5;
    localparam logic [2:0] WM_RESV6 = 3'h6;
    localparam logic [2:0] WM_FAST_A = 3'h7;
    // Output modes
    localparam logic [1:0] OM_OFF = 2'h0;
    localparam logic [1:0] OM_TOGGLE = 2'h1;
    localparam logic [1:0] OM_CLEAR = 2'h2;
    localparam logic [1:0] OM_SET = 2'h3;
    // Tick source selections
    localparam logic [2:0] TS_STOP = 3'h0;
    localparam logic [2:0] TS_DIV1 = 3'h1;
    localparam logic [2:0] TS_DIV8 = 3'h2;
    localparam logic [2:0] TS_DIV64 = 3'h3;
    localparam logic [2:0] TS_DIV256 = 3'h4;
    localparam logic [2:0] TS_DIV1024 = 3'h5;
    localparam logic [2:0] TS_EXT_FALL = 3'h6;
    localparam logic [2:0] TS_EXT_RISE = 3'h7;
    // Bus slave states
    typedef enum logic [1:0] {
        TMR8_BUS_IDLE = 2'b01,
        TMR8_BUS_ANS = 2'b10
    } tmr8_bus_e;
endpackage

// *** bench/tb_top.sv ***
// Self-checking bench for the 8-bit timer waveform and compare block.
// Assumes the design package is compiled first; bus is Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
import tmr8_pkg::*;
logic clk = 1'b0;
logic reset_n = 1'b0;
logic [4:0] avs_address = 5'h00;
logic avs_read = 1'b0;
logic avs_write = 1'b0;
logic [31:0] avs_writedata = 32'h0000_0000;
logic [3:0] avs_byteenable = 4'hF;
logic ext_tick_in = 1'b0;
logic chan_a_dir = 1'b1;
logic chan_b_dir = 1'b1;
logic port_a_out = 1'b0;
logic port_b_out = 1'b0;
logic [31:0] avs_readdata;
logic avs_waitrequest, pin_a_out, pin_a_oe, pin_b_out, pin_b_oe;
logic chan_a_wave_out, chan_b_wave_out;
logic overflow_flag, chan_a_match_flag, chan_b_match_flag;
logic [31:0] seed = 32'h0000_26F7;
logic [31:0] pr;
logic [7:0] q, c;
logic [1:0] wv = 2'b00;
logic prev;
logic [4:0] ra [3] = '{ADDR_COUNT, ADDR_CMP_A, ADDR_CMP_B};
int failures = 0;
int tests_run = 0;
int cyc = 0;
int hi, tg, k;

tmr8_wave_ctrl tmr8_wave_ctrl_i (.clk(clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_tick_in(ext_tick_in),
    .chan_a_dir(chan_a_dir), .chan_b_dir(chan_b_dir),
    .port_a_out(port_a_out), .port_b_out(port_b_out),
    .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out),
    .pin_b_oe(pin_b_oe), .chan_a_wave_out(chan_a_wave_out),
    .chan_b_wave_out(chan_b_wave_out), .overflow_flag(overflow_flag),
    .chan_a_match_flag(chan_a_match_flag),
    .chan_b_match_flag(chan_b_match_flag));

initial begin
    forever #20 clk = ~clk;
end

function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
endfunction

// Expected wave after one compare action of a non-PWM output mode
function automatic logic fwave(logic [1:0] om, logic cur);
    return (om == OM_TOGGLE) ? ~cur : (om == OM_SET);
endfunction

function automatic logic [7:0] ctl_a(int ch, logic [1:0] om, logic [1:0] wl);
    return ch ? {2'b00, om, 2'b00, wl} : {om, 4'h0, wl};
endfunction

// High cycles over four periods; phase PWM spends about 2c of 510 high
function automatic int duty_exp(int wi, logic [1:0] om, logic [7:0] c);
    int h;
    int t;
    h = wi ? 8 * int'(c) : 4 * (int'(c) + 1);
    t = wi ? 2040 : 1024;
    return (om == OM_SET) ? t - h : h;
endfunction

function automatic logic [7:0] tick_exp(int s);
    int sh [5] = '{0, 3, 6, 8, 10};
    return 8'(1024 >> sh[s - 1]);
endfunction

task automatic stop_test;
    if (failures == 0 && tests_run > 0) begin
        $display("Simulation passed");
    end else begin
        $display("Simulation failed");
    end
    $finish;
endtask

task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
        failures++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask

// Reports the distance itself when it lies outside the tolerance
task automatic near(input int d, input int tol);
    chk((d <= tol && d >= -tol) ? 32'h0000_0000 : d, 32'h0000_0000);
endtask

task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                   input logic [3:0] be, output logic [7:0] rq);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= ~w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rq = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
endtask

task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    bus(1'b1, a, d, 4'hF, dummy);
endtask

task automatic rd(input logic [4:0] a, output logic [7:0] rq);
    bus(1'b0, a, 8'h00, 4'hF, rq);
endtask

task automatic restart(input logic [7:0] cnt);
    wr(ADDR_CTRL_B, {5'h00, TS_STOP});
    wr(ADDR_COUNT, cnt);
endtask

// Port data changes every cycle so a stuck pin mux shows up
always @(posedge clk) begin
    pr = rnd();
    port_a_out <= pr[0];
    port_b_out <= pr[1];
end

// Ceiling well above the roughly 24k cycles the sequence needs
always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
        failures++;
        stop_test();
    end
end

initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(ADDR_CTRL_A, q);
    chk(q, CTRL_A_RESET);
    rd(ADDR_CTRL_B, q);
    chk(q, CTRL_B_RESET);
    // Forced compares with the tick stopped, toggle, clear and set output modes
    for (int ch = 0; ch < 2; ch++) begin
        for (int om = 1; om < 4; om++) begin
            wr(ADDR_CTRL_A, ctl_a(ch, 2'(om), 2'b00));
            wr(ADDR_CTRL_B, ch ? 8'h40 : 8'h80);
            wv[ch] = fwave(2'(om), wv[ch]);
            repeat (2) @(posedge clk);
            chk(ch ? chan_b_wave_out : chan_a_wave_out, wv[ch]);
            chk(ch ? pin_b_out : pin_a_out, wv[ch]);
            chk(ch ? pin_b_oe : pin_a_oe, 1'b1);
            chk({overflow_flag, chan_a_match_flag, chan_b_match_flag}, 0);
        end
    end
    rd(ADDR_CTRL_B, q);
    chk(q, 8'h00);
    chan_a_dir <= 1'b0;
    wr(ADDR_CTRL_A, 8'h00);
    chk(pin_a_oe, 1'b0);
    chk(pin_a_out, port_a_out);
    chan_a_dir <= 1'b1;
    // Read-only bits, dropped byte lane, unmapped address
    wr(ADDR_CTRL_A, 8'hFF);
    rd(ADDR_CTRL_A, q);
    chk(q, CTRL_A_WMASK);
    wr(ADDR_CTRL_B, 8'hF0);
    rd(ADDR_CTRL_B, q);
    chk(q, 8'h00);
    bus(1'b1, ADDR_CTRL_A, 8'h00, 4'h0, q);
    rd(ADDR_CTRL_A, q);
    chk(q, CTRL_A_WMASK);
    rd(5'h18, q);
    chk(q, 8'h00);
    repeat (6) begin
        k = int'(rnd() % 3);
        c = 8'(rnd());
        wr(ra[k], c);
        rd(ra[k], q);
        chk(q, c);
    end
    // Each internal tick rate over 1024 clocks, counter stopped to read
    wr(ADDR_CTRL_A, 8'h00);
    for (int s = 1; s < 6; s++) begin
        restart(8'h00);
        wr(ADDR_CTRL_B, 8'(s));
        repeat (1024) @(posedge clk);
        wr(ADDR_CTRL_B, {5'h00, TS_STOP});
        rd(ADDR_COUNT, q);
        near(int'($signed(8'(q - tick_exp(s)))), 4);
        repeat (20) @(posedge clk);
        rd(ADDR_COUNT, c);
        chk(c, q);
    end
    for (int s = 6; s < 8; s++) begin
        restart(8'h00);
        wr(ADDR_CTRL_B, 8'(s));
        repeat (20) begin
            ext_tick_in <= 1'b1;
            repeat (3) @(posedge clk);
            ext_tick_in <= 1'b0;
            repeat (3) @(posedge clk);
        end
        wr(ADDR_CTRL_B, {5'h00, TS_STOP});
        rd(ADDR_COUNT, q);
        chk(q, 8'h14);
    end
    // Clear-on-match: count never passes compare A, MAX never reached
    restart(8'h00);
    wr(ADDR_CMP_A, 8'h10);
    wr(ADDR_CMP_B, 8'h08);
    wr(ADDR_CTRL_A, {6'h00, WM_CLEAR[1:0]});
    wr(ADDR_FLAGS, 8'h07);
    wr(ADDR_CTRL_B, {5'h00, TS_DIV1});
    repeat (8) begin
        rd(ADDR_COUNT, q);
        chk(q <= 8'h10, 1'b1);
    end
    repeat (300) @(posedge clk);
    chk(chan_a_match_flag, 1'b1);
    chk(chan_b_match_flag, 1'b1);
    chk(overflow_flag, 1'b0);
    wr(ADDR_CTRL_A, 8'h40);
    wr(ADDR_FLAGS, 8'h07);
    repeat (300) @(posedge clk);
    chk(overflow_flag, 1'b1);
    // PWM duty in fast and phase-correct modes, both polarities
    for (int ch = 0; ch < 2; ch++) begin
        for (int wi = 0; wi < 2; wi++) begin
            for (int om = 2; om < 4; om++) begin
                c = 8'h20 + 8'(rnd() % 192);
                restart(8'h00);
                wr(ADDR_CMP_A, c);
                wr(ADDR_CMP_B, c);
                wr(ADDR_CTRL_A, ctl_a(ch, 2'(om), wi ? 2'b01 : 2'b11));
                wr(ADDR_CTRL_B, {5'h00, TS_DIV1});
                repeat (600) @(posedge clk);
                hi = 0;
                repeat (wi ? 2040 : 1024) begin
                    @(posedge clk);
                    hi += ch ? int'(chan_b_wave_out) : int'(chan_a_wave_out);
                end
                near(hi - duty_exp(wi, 2'(om), c), 12);
            end
        end
    end
    // Toggle without the high mode bit, reserved B mode: both disconnected
    wr(ADDR_CTRL_A, 8'h53);
    repeat (40) begin
        @(posedge clk);
        chk({pin_a_out, pin_b_out}, {port_a_out, port_b_out});
    end
    // Reserved waveform mode 4 with both output modes set: disconnected
    wr(ADDR_CTRL_B, 8'h08);
    wr(ADDR_CTRL_A, 8'hF0);
    repeat (8) begin
        @(posedge clk);
        chk({pin_a_out, pin_b_out}, {port_a_out, port_b_out});
    end
    // Mode 7: compare A is TOP, toggle once per period of 16 ticks
    // Compares written in mode 0 so TOP is known before PWM starts
    restart(8'h00);
    wr(ADDR_CTRL_A, 8'h00);
    wr(ADDR_CMP_A, 8'h0F);
    wr(ADDR_CMP_B, 8'h0F);
    wr(ADDR_CTRL_A, 8'h63);
    wr(ADDR_FLAGS, 8'h07);
    wr(ADDR_CTRL_B, 8'h09);
    repeat (40) @(posedge clk);
    chk(overflow_flag, 1'b1);
    tg = 0;
    prev = pin_a_out;
    repeat (320) begin
        @(posedge clk);
        if (pin_a_out !== prev) begin
            tg++;
        end
        prev = pin_a_out;
    end
    near(tg - 20, 1);
    rd(ADDR_COUNT, q);
    chk(q <= 8'h0F, 1'b1);
    chk(chan_b_wave_out, 1'b1);
    stop_test();
end
endmodule
`default_nettype wire
